// File: design/pw_pkg.sv
/*
  Constants, register map and carrier types of the page walker.
  Assumes a single clock domain and a 32-bit register bus.
*/
`default_nettype none
package pw_pkg;
  localparam int PA_W = 52;
  localparam int LA_W = 48;
  localparam int STRUCT_BYTES = 4096;
  localparam logic [5:0] PAGE_SHIFT = 6'h0c;
  localparam logic [5:0] SH_TWO_TOP = 6'h16;
  localparam logic [5:0] SH_EXT_TOP = 6'h1e;
  localparam logic [5:0] SH_FOUR_TOP = 6'h27;
  localparam logic [5:0] SH_DIR_WIDE = 6'h15;
  localparam logic [5:0] SH_PTR_WIDE = 6'h1e;
  localparam logic [3:0] SLICE_TWO = 4'ha;
  localparam logic [3:0] SLICE_WIDE = 4'h9;
  localparam logic [3:0] SLICE_EXT_TOP = 4'h2;
  localparam int PRESENT_BIT = 0;
  localparam int PAGE_SIZE_BIT = 7;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ROOT_LO = 8'h04;
  localparam logic [7:0] REG_ROOT_HI = 8'h08;
  localparam logic [7:0] REG_RSVD_LO = 8'h0c;
  localparam logic [7:0] REG_RSVD_HI = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_INT_STATUS = 8'h18;
  localparam logic [7:0] REG_INT_MASK = 8'h1c;
  localparam int CTRL_LPE_BIT = 2;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_FAULT_BIT = 1;
  localparam logic [PA_W-1:0] ROOT_RESET = 52'h0;
  localparam logic [63:0] RSVD_RESET = 64'h0;
  localparam logic [1:0] INT_RESET = 2'h0;
  typedef enum logic [1:0] {
    MODE_TWO_LEVEL = 2'b00,
    MODE_EXT_PHYS = 2'b01,
    MODE_FOUR_LEVEL = 2'b10
  } walk_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_WAIT = 2'b10,
    ST_DONE = 2'b11
  } walk_state_t;
  typedef struct packed {
    logic [PA_W-1:0] addr;
    logic wide;
  } mem_req_t;
  typedef struct packed {
    logic fault;
    logic [PA_W-1:0] phys;
    logic [PA_W-1:0] frame;
    logic [29:0] offset;
    logic [5:0] page_shift;
  } cpl_t;
endpackage
`default_nettype wire

// File: design/hierarchical_page_walker.sv
/*
  Hierarchical page-table walker with an AHB-Lite register slave.
  Assumes a memory port that answers each entry read once, in order,
  with the entry in the low bits of mem_rsp_data.
*/
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module hierarchical_page_walker
  import pw_pkg::*;
#(
  parameter bit GBYTE_PAGES = 1'b1,
  parameter int REG_AW = 8
)(
  input wire logic hclk, // Bus and walker clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic [31:0] hrdata, // Read data.
  output logic hresp, // Response, always OKAY.
  input wire logic req_valid, // Translation request.
  output logic req_ready, // Walker idle.
  input wire logic [LA_W-1:0] req_laddr, // Linear address.
  output logic mem_req_valid, // Entry read request.
  input wire logic mem_req_ready, // Memory takes the read.
  output var mem_req_t mem_req, // Entry address and size.
  input wire logic mem_rsp_valid, // Entry data valid.
  input wire logic [63:0] mem_rsp_data, // Entry data.
  output logic cpl_valid, // Completion pulse.
  output var cpl_t cpl, // Completion contents.
  output logic irq // Level interrupt.
);
  if (REG_AW < 5 || REG_AW > 32)
  begin : g_bad_aw
    $error("REG_AW must lie between 5 and 32");
  end

  walk_state_t state_q;
  walk_mode_t mode_q, wmode_q;
  logic lpe_q, wlpe_q, last_fault_q;
  logic [PA_W-1:0] root_q, base_q;
  logic [63:0] rsvd_q, wrsvd_q;
  logic [LA_W-1:0] laddr_q;
  logic [5:0] shift_q;
  logic [1:0] lvl_q, int_st_q, int_mask_q;
  logic [REG_AW-1:0] a_q;
  logic wr_q;

  // Bus slave: zero wait states, unmapped reads give zero.
  wire ahb_go = hsel & hready & htrans[1];
  wire [7:0] wa = 8'(a_q);
  wire w_ctrl = wr_q & (wa == REG_CTRL);
  wire w_rlo = wr_q & (wa == REG_ROOT_LO);
  wire w_rhi = wr_q & (wa == REG_ROOT_HI);
  wire w_slo = wr_q & (wa == REG_RSVD_LO);
  wire w_shi = wr_q & (wa == REG_RSVD_HI);
  wire w_ist = wr_q & (wa == REG_INT_STATUS);
  wire w_imk = wr_q & (wa == REG_INT_MASK);
  wire [7:0] ra = 8'(haddr[REG_AW-1:0]);
  wire [31:0] stat_word = {26'h0, lvl_q, 1'b0, GBYTE_PAGES,
    last_fault_q, state_q != ST_IDLE};
  wire [31:0] rd_mux =
    (ra == REG_CTRL) ? {29'h0, lpe_q, mode_q} :
    (ra == REG_ROOT_LO) ? root_q[31:0] :
    (ra == REG_ROOT_HI) ? {12'h0, root_q[PA_W-1:32]} :
    (ra == REG_RSVD_LO) ? rsvd_q[31:0] :
    (ra == REG_RSVD_HI) ? rsvd_q[63:32] :
    (ra == REG_STATUS) ? stat_word :
    (ra == REG_INT_STATUS) ? {30'h0, int_st_q} :
    (ra == REG_INT_MASK) ? {30'h0, int_mask_q} : 32'h0;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      a_q <= '0;
      hrdata <= 32'h0;
    end
    else
    begin
      wr_q <= ahb_go & hwrite;
      if (ahb_go)
        a_q <= haddr[REG_AW-1:0];
      if (ahb_go & ~hwrite)
        hrdata <= rd_mux;
    end
  end

  // Control registers; an undefined mode code is not stored.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_q <= MODE_TWO_LEVEL;
      lpe_q <= 1'b0;
      root_q <= ROOT_RESET;
      rsvd_q <= RSVD_RESET;
      int_mask_q <= INT_RESET;
    end
    else
    begin
      if (w_ctrl && hwdata[1:0] != 2'b11)
        mode_q <= walk_mode_t'(hwdata[1:0]);
      if (w_ctrl)
        lpe_q <= hwdata[CTRL_LPE_BIT];
      if (w_rlo)
        root_q[31:0] <= hwdata;
      if (w_rhi)
        root_q[PA_W-1:32] <= hwdata[PA_W-33:0];
      if (w_slo)
        rsvd_q[31:0] <= hwdata;
      if (w_shi)
        rsvd_q[63:32] <= hwdata;
      if (w_imk)
        int_mask_q <= hwdata[1:0];
    end
  end

  // Walk datapath.
  wire two = wmode_q == MODE_TWO_LEVEL;
  wire four = wmode_q == MODE_FOUR_LEVEL;
  wire top_wide = (lvl_q == 2'h0) & ~two;
  wire [3:0] slice_w = two ? SLICE_TWO :
    (wmode_q == MODE_EXT_PHYS && lvl_q == 2'h0) ? SLICE_EXT_TOP :
    SLICE_WIDE;
  wire [LA_W-1:0] idx_raw = laddr_q >> shift_q;
  wire [9:0] idx = idx_raw[9:0] & ~(10'h3ff << slice_w);
  wire [PA_W-1:0] idx_off = two ? {40'h0, idx, 2'h0} : {39'h0, idx, 3'h0};
  assign mem_req.addr = base_q + idx_off;
  assign mem_req.wide = ~two;
  assign mem_req_valid = state_q == ST_FETCH;
  assign req_ready = state_q == ST_IDLE;
  assign cpl_valid = state_q == ST_DONE;

  // Root base: 4K aligned, except the 32-byte extended top table.
  wire [PA_W-1:0] root_base =
    (mode_q == MODE_FOUR_LEVEL) ? {root_q[PA_W-1:12], 12'h0} :
    (mode_q == MODE_EXT_PHYS) ? {20'h0, root_q[31:5], 5'h0} :
    {20'h0, root_q[31:12], 12'h0};
  wire [5:0] top_shift =
    (mode_q == MODE_FOUR_LEVEL) ? SH_FOUR_TOP :
    (mode_q == MODE_EXT_PHYS) ? SH_EXT_TOP : SH_TWO_TOP;

  wire [63:0] ent = two ? {32'h0, mem_rsp_data[31:0]} : mem_rsp_data;
  wire [63:0] rsvd_eff = (two & ~wlpe_q) ? 64'h0 : wrsvd_q;
  wire present = ent[PRESENT_BIT];
  wire rsvd_hit = |(ent & rsvd_eff);
  wire ps = ent[PAGE_SIZE_BIT];
  wire is_last = shift_q == PAGE_SHIFT;
  wire can_big = two ? wlpe_q :
    (shift_q == SH_DIR_WIDE) |
    (four & (shift_q == SH_PTR_WIDE) & GBYTE_PAGES);
  wire bad_gb = four & (shift_q == SH_PTR_WIDE) & ps & ~GBYTE_PAGES
    & ~top_wide;
  wire map_large = ~is_last & ps & can_big & ~top_wide;
  wire fault = ~present | rsvd_hit | bad_gb;
  wire maps = is_last | map_large;
  wire [PA_W-1:0] next_tbl = two ? {20'h0, ent[31:12], 12'h0} :
    {ent[PA_W-1:12], 12'h0};
  wire [PA_W-1:0] big32 = {12'h0, ent[20:13], ent[31:22], 22'h0};
  wire [PA_W-1:0] map_addr = (two & map_large) ? big32 : next_tbl;
  wire [PA_W-1:0] page_mask = ~({PA_W{1'b1}} << shift_q);
  wire [PA_W-1:0] frame = map_addr & ~page_mask;
  wire [29:0] offset = laddr_q[29:0] & page_mask[29:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ST_IDLE;
      wmode_q <= MODE_TWO_LEVEL;
      wlpe_q <= 1'b0;
      wrsvd_q <= RSVD_RESET;
      laddr_q <= '0;
      base_q <= '0;
      shift_q <= PAGE_SHIFT;
      lvl_q <= 2'h0;
      cpl <= '0;
      last_fault_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (req_valid)
          begin
            wmode_q <= mode_q;
            wlpe_q <= lpe_q;
            wrsvd_q <= rsvd_q;
            laddr_q <= (mode_q == MODE_FOUR_LEVEL) ? req_laddr :
              {16'h0, req_laddr[31:0]};
            base_q <= root_base;
            shift_q <= top_shift;
            lvl_q <= 2'h0;
            state_q <= ST_FETCH;
          end
        ST_FETCH:
          if (mem_req_ready)
            state_q <= ST_WAIT;
        ST_WAIT:
          if (mem_rsp_valid)
          begin
            if (fault | maps)
            begin
              cpl.fault <= fault;
              cpl.phys <= fault ? '0 : (frame | {22'h0, offset});
              cpl.frame <= fault ? '0 : frame;
              cpl.offset <= fault ? '0 : offset;
              cpl.page_shift <= shift_q;
              last_fault_q <= fault;
              state_q <= ST_DONE;
            end
            else
            begin
              base_q <= next_tbl;
              shift_q <= shift_q - (two ? 6'h0a : 6'h09);
              lvl_q <= lvl_q + 2'h1;
              state_q <= ST_FETCH;
            end
          end
        ST_DONE:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Sticky events; a new event beats a same-cycle clear.
  wire [1:0] ev = {cpl_valid & cpl.fault, cpl_valid};
  wire [1:0] clr = w_ist ? hwdata[1:0] : 2'h0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_st_q <= INT_RESET;
    else
      int_st_q <= (int_st_q & ~clr) | ev;
  end
  assign irq = |(int_st_q & int_mask_q);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_one_read;
    mem_req_valid && mem_req_ready |=> !mem_req_valid;
  endproperty
  a_one_read: assert property (p_one_read) else $error("second read");

  property p_cpl_pulse;
    cpl_valid |=> !cpl_valid && req_ready;
  endproperty
  a_cpl_pulse: assert property (p_cpl_pulse) else $error("long cpl");

  property p_four_top;
    mem_req_valid && four && lvl_q == 2'h0 |-> mem_req.addr[11:3]
      == laddr_q[47:39] && mem_req.addr[51:12] == base_q[51:12];
  endproperty
  a_four_top: assert property (p_four_top) else $error("bad top");

  property p_two_slices;
    mem_req_valid && two |-> mem_req.addr[11:2] ==
      (lvl_q == 2'h0 ? laddr_q[31:22] : laddr_q[21:12]);
  endproperty
  a_two_slices: assert property (p_two_slices) else $error("bad slice");

  property p_ext_top;
    mem_req_valid && wmode_q == MODE_EXT_PHYS && lvl_q == 2'h0
      |-> mem_req.addr[4:3] == laddr_q[31:30] && mem_req.addr[2:0] == 3'h0;
  endproperty
  a_ext_top: assert property (p_ext_top) else $error("bad ext top");

  property p_absent;
    state_q == ST_WAIT && mem_rsp_valid && !present
      |=> cpl_valid && cpl.fault ##1 int_st_q[INT_FAULT_BIT];
  endproperty
  a_absent: assert property (p_absent) else $error("no fault");

  property p_leaf;
    state_q == ST_WAIT && mem_rsp_valid && !fault && is_last
      |=> cpl_valid && !cpl.fault && cpl.page_shift == PAGE_SHIFT;
  endproperty
  a_leaf: assert property (p_leaf) else $error("leaf not 4K");

  property p_no_pse;
    state_q == ST_WAIT && mem_rsp_valid && !fault && two
      && lvl_q == 2'h0 && !wlpe_q |=> state_q == ST_FETCH;
  endproperty
  a_no_pse: assert property (p_no_pse) else $error("4M w/o enable");

  property p_top_ref;
    state_q == ST_WAIT && mem_rsp_valid && !fault && top_wide
      |=> state_q == ST_FETCH && lvl_q == 2'h1;
  endproperty
  a_top_ref: assert property (p_top_ref) else $error("top mapped");

  property p_offset;
    cpl_valid && !cpl.fault |-> cpl.phys[11:0] == laddr_q[11:0];
  endproperty
  a_offset: assert property (p_offset) else $error("bad offset");

  // A read that waits for the memory keeps its address and size.
  property p_read_hold;
    mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read moved");

  property p_in_struct;
    mem_req_valid |-> (mem_req.addr - base_q) < STRUCT_BYTES;
  endproperty
  a_in_struct: assert property (p_in_struct) else $error("outside table");

  property p_ref_next;
    state_q == ST_WAIT && mem_rsp_valid && !fault && !maps
      |=> mem_req_valid && base_q == $past(next_tbl);
  endproperty
  a_ref_next: assert property (p_ref_next) else $error("bad next table");

  property p_rsvd;
    state_q == ST_WAIT && mem_rsp_valid && present && rsvd_hit
      |=> cpl_valid && cpl.fault;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved not faulted");

  // Every large page must report the size of the slice that it covers.
  property p_big_two;
    state_q == ST_WAIT && mem_rsp_valid && !fault && two && wlpe_q
      && lvl_q == 2'h0 && ps |=> cpl_valid && cpl.page_shift == SH_TWO_TOP
      && cpl.frame[21:0] == 22'h0;
  endproperty
  a_big_two: assert property (p_big_two) else $error("bad 4M page");

  property p_dir_wide;
    state_q == ST_WAIT && mem_rsp_valid && !fault && !two
      && shift_q == SH_DIR_WIDE && ps
      |=> cpl_valid && !cpl.fault && cpl.page_shift == SH_DIR_WIDE;
  endproperty
  a_dir_wide: assert property (p_dir_wide) else $error("bad 2M page");

  property p_gbyte;
    state_q == ST_WAIT && mem_rsp_valid && !fault && four
      && shift_q == SH_PTR_WIDE && ps
      |=> cpl_valid && GBYTE_PAGES && cpl.page_shift == SH_PTR_WIDE;
  endproperty
  a_gbyte: assert property (p_gbyte) else $error("bad 1G page");
endmodule // hierarchical_page_walker
`default_nettype wire

// File: dv/pw_mem_model.sv
/*
  Memory model that holds the paging structures for the walker bench.
  Assumes that the bench fills mem by hierarchical reference before each walk.
*/
`timescale 1ns/100ps
`default_nettype none
module pw_mem_model
  import pw_pkg::*;
(
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset, active low.
  input wire logic slow, // Stall and answer late when high.
  input wire logic mem_req_valid, // Read offered.
  output logic mem_req_ready, // Read taken.
  input wire mem_req_t mem_req, // Entry address and size.
  output logic mem_rsp_valid, // Entry data valid.
  output logic [63:0] mem_rsp_data // Entry data.
);
  logic [63:0] mem [logic [PA_W-1:0]];
  logic busy_q;
  logic tog_q;
  logic wide_q;
  logic [2:0] cnt_q;
  logic [PA_W-1:0] addr_q;
  logic [63:0] ent;
  assign mem_req_ready = !busy_q && !(slow && tog_q);
  // Outside a response the data bus toggles, so a stale entry is never mistaken for a fresh one.
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      busy_q <= 1'b0;
      tog_q <= 1'b0;
      wide_q <= 1'b0;
      cnt_q <= 3'h0;
      addr_q <= '0;
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= 64'h0;
    end
    else
    begin
      tog_q <= !tog_q;
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= ~mem_rsp_data;
      if (mem_req_valid && mem_req_ready)
      begin
        busy_q <= 1'b1;
        addr_q <= mem_req.addr;
        wide_q <= mem_req.wide;
        cnt_q <= slow ? 3'h3 : 3'h0;
      end
      else if (busy_q && cnt_q != 3'h0)
        cnt_q <= cnt_q - 3'h1;
      else if (busy_q)
      begin
        busy_q <= 1'b0;
        mem_rsp_valid <= 1'b1;
        ent = mem.exists(addr_q) ? mem[addr_q] : 64'h0;
        mem_rsp_data <= wide_q ? ent : {~ent[31:0], ent[31:0]};
      end
    end
endmodule // pw_mem_model
`default_nettype wire

// File: dv/test_hierarchical_page_walker.sv
/*
  Self-checking bench of the page walker: builds random paging structures and checks each walk.
  Assumes pw_mem_model answers entry reads and that one slave owns the register bus.
*/
`timescale 1ns/100ps
`default_nettype none
module test_hierarchical_page_walker
  import pw_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic req_valid = 1'b0;
  logic [LA_W-1:0] req_laddr = 48'h0;
  logic slow = 1'b0;
  logic hreadyout, hresp, req_ready, mem_req_valid, mem_req_ready, mem_rsp_valid, cpl_valid, irq;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [63:0] mem_rsp_data;
  mem_req_t mem_req;
  cpl_t cpl;
  int seed = 60;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  logic [52:0] exp_q[$];
  logic [52:0] got_q[$];
  always #12.5 hclk = ~hclk;
  hierarchical_page_walker hierarchical_page_walker_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .req_valid(req_valid), .req_ready(req_ready), .req_laddr(req_laddr),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req(mem_req),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data), .cpl_valid(cpl_valid),
    .cpl(cpl), .irq(irq));
  pw_mem_model pw_mem_model_inst (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req(mem_req),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));
  always @(posedge hclk)
    if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1)
      got_q.push_back({mem_req.wide, mem_req.addr});
  task automatic finish_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test;
    end
  end
  task automatic chk(input logic [159:0] got, input logic [159:0] want);
    checked++;
    if (got !== want)
    begin
      n_fail++;
      $display("mismatch at %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask
  function automatic int sh_of(input int md, input int i);
    return 12 + (md + 1 - i) * (md == 0 ? 10 : 9);
  endfunction
  function automatic int leaf_of(input int md, input bit lpe, input int ps);
    if ((md == 0 && ps == 0 && lpe) || (md > 0 && ps > 0 && ps <= md))
      return ps;
    return md + 1;
  endfunction
  task automatic run(input int md, input bit lpe, input int ps, input int fl, input bit rk);
    int lf;
    int last;
    int s;
    logic [63:0] b, e, fr, lr, la, ea, off;
    lf = leaf_of(md, lpe, ps);
    last = fl < lf ? fl : lf;
    s = sh_of(md, lf);
    lr = {$random(seed), $random(seed)};
    la = md == 2 ? lr & 64'hffff_ffff_ffff : lr & 64'hffff_ffff;
    off = la & ((64'h1 << s) - 1);
    fr = ({$random(seed), $random(seed)} & (md == 2 ? 64'hff_ffff_ffff : 64'hffff_ffff)) >> s << s;
    b = md == 1 ? {$random(seed)} & 32'hf_ffe0 | 32'h1000 : {$random(seed)} & 32'hf_f000 | 32'h1000;
    ahb(1'b1, REG_CTRL, {29'h0, lpe, md[1:0]});
    ahb(1'b1, REG_ROOT_LO, b[31:0]);
    pw_mem_model_inst.mem.delete();
    exp_q.delete();
    for (int i = 0; i <= last; i++)
    begin
      ea = b + ((la >> sh_of(md, i)) & (md == 0 ? 64'h3ff : 64'h1ff)) * (md == 0 ? 64'h4 : 64'h8);
      exp_q.push_back({md != 0, ea[51:0]});
      b = 64'h10_0000 * (i + 1);
      e = (i == lf ? fr : b) | 64'h1 | (i == ps ? 64'h80 : 64'h0);
      if (i == fl)
        e = rk ? e | 64'h200 : e & ~64'h1;
      pw_mem_model_inst.mem[ea[51:0]] = e;
    end
    got_q.delete();
    slow <= 1'($random(seed));
    req_valid <= 1'b1;
    req_laddr <= lr[47:0];
    do @(posedge hclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(posedge hclk); while (cpl_valid !== 1'b1);
    chk(got_q.size(), exp_q.size());
    foreach (exp_q[k])
      chk(got_q[k], exp_q[k]);
    chk(cpl.fault, fl <= lf);
    if (fl > lf)
      chk({cpl.phys, cpl.frame, cpl.offset, cpl.page_shift},
        {fr[51:0] | off[51:0], fr[51:0], off[29:0], 6'(s)});
    ahb(1'b0, REG_INT_STATUS, 32'h0);
    chk({rd[1:0], irq}, {fl <= lf, 1'b1, fl <= lf});
    ahb(1'b1, REG_INT_STATUS, 32'h3);
    @(posedge hclk);
    chk(irq, 1'b0);
  endtask
  initial
  begin
    int md;
    bit lpe, rk;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd[2:0], 3'b100);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, REG_CTRL, 32'h6);
    ahb(1'b1, REG_CTRL, 32'h3);
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h2);
    ahb(1'b1, REG_ROOT_HI, 32'hffff_ffff);
    ahb(1'b0, REG_ROOT_HI, 32'h0);
    chk(rd, 32'h000f_ffff);
    ahb(1'b1, REG_ROOT_HI, 32'h0);
    ahb(1'b1, REG_RSVD_LO, 32'h200);
    ahb(1'b1, REG_INT_MASK, 32'h2);
    run(2, 0, 9, 9, 0);
    run(2, 0, 1, 9, 0);
    run(2, 0, 2, 9, 0);
    run(2, 0, 0, 9, 0);
    run(2, 0, 3, 9, 0);
    run(1, 0, 0, 9, 0);
    run(1, 0, 1, 9, 0);
    run(0, 1, 0, 9, 0);
    run(0, 0, 0, 9, 0);
    run(0, 1, 1, 9, 0);
    run(2, 0, 9, 2, 0);
    run(2, 0, 9, 3, 1);
    run(0, 0, 9, 0, 0);
    repeat (16)
    begin
      md = {$random(seed)} % 3;
      lpe = 1'($random(seed));
      rk = 1'($random(seed)) && !(md == 0 && !lpe);
      run(md, lpe, {$random(seed)} % 5, {$random(seed)} % 6, rk);
    end
    finish_test;
  end
endmodule // test_hierarchical_page_walker
`default_nettype wire
